/* File: core/fpss_pkg.sv */
/*
 Package for the flash protect, security and swap controller: register
 offsets, field positions, reset values, key, timing and command carriers.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package fpss_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] FPSS_OFF_SECLOCK  = 12'h010;
   localparam logic [11:0] FPSS_OFF_PROT_LO  = 12'h020;
   localparam logic [11:0] FPSS_OFF_PROT_HI  = 12'h030;
   localparam logic [11:0] FPSS_OFF_ABSTAT   = 12'h100;
   localparam logic [11:0] FPSS_OFF_SWAP     = 12'h104;
   localparam logic [11:0] FPSS_OFF_AREA     = 12'h140;
   localparam logic [11:0] FPSS_OFF_OPCTL    = 12'h148;
   localparam logic [11:0] FPSS_OFF_ABCLR    = 12'h14C;
   localparam logic [11:0] FPSS_OFF_WCLKDIV  = 12'h150;
   localparam logic [11:0] FPSS_OFF_PROGCNT  = 12'h154;
   localparam logic [11:0] FPSS_OFF_ERASECNT = 12'h158;
   localparam logic [11:0] FPSS_OFF_CMD      = 12'h200;
   localparam logic [11:0] FPSS_OFF_DONE     = 12'h204;

   // ------------------------------------------------------------
   // Field positions and values
   // ------------------------------------------------------------
   localparam int          FPSS_BLK_LO_POS   = 17;
   localparam int          FPSS_PAGE_POS     = 8;
   localparam int          FPSS_BLK_HI_POS   = 16;
   localparam int          FPSS_SWSIZE_POS   = 8;
   localparam int          FPSS_FLAG_POS     = 2;
   localparam int          FPSS_ABORTED_POS  = 24;
   localparam logic [31:0] FPSS_UNLOCK_KEY   = 32'hA74A9D23;
   localparam logic [2:0]  FPSS_ABORT_CODE   = 3'h7;
   localparam logic [2:0]  FPSS_AREA_SEL     = 3'h7;
   localparam logic [1:0]  FPSS_SWP_ACTIVE   = 2'h1;
   localparam logic [1:0]  FPSS_SWP_IDLE     = 2'h0;
   localparam logic [2:0]  FPSS_SIZE_MAX     = 3'h4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic        FPSS_RST_SECURE   = 1'b1;
   localparam logic [3:0]  FPSS_RST_ERASECNT = 4'h6;

   // ------------------------------------------------------------
   // Timing: key window in clocks
   // ------------------------------------------------------------
   localparam logic [4:0]  FPSS_KEY_WINDOW   = 5'h10;

   // ------------------------------------------------------------
   // Commands issued through the command register
   // ------------------------------------------------------------
   localparam logic [3:0]  FPSS_CMD_PROT_PROG  = 4'h1;
   localparam logic [3:0]  FPSS_CMD_PROT_ERASE = 4'h2;
   localparam logic [3:0]  FPSS_CMD_PROGRAM    = 4'h3;
   localparam logic [3:0]  FPSS_CMD_BLK_ERASE  = 4'h4;
   localparam logic [3:0]  FPSS_CMD_PAGE_ERASE = 4'h5;
   localparam logic [3:0]  FPSS_CMD_CHIP_ERASE = 4'h6;
   localparam logic [3:0]  FPSS_CMD_SWAP       = 4'h7;

   typedef struct packed {
      logic [3:0] opcode;
      logic [4:0] block;
      logic [2:0] page;
      logic [1:0] swap_bits;
      logic [2:0] swap_size;
      logic [5:0] flags;
   } fpss_cmd_s;

   typedef enum logic [1:0] {
      FPSS_IDLE = 2'b01,
      FPSS_BUSY = 2'b10
   } fpss_state_e;

endpackage

/* File: core/fpss_top.sv */
/*
 Flash protect, security and swap controller with its register map.
 Assumes a classic Wishbone master on the system clock, and a flash
 engine that reports the end or failure of each automatic operation.
*/
`timescale 1ns/10ps
`default_nettype none
module fpss_top
   import fpss_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cold_rst_i,
   input  wire logic        stop_wake_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        op_done_i,
   input  wire logic        op_fail_i,
   output logic             op_start_o,
   output var fpss_cmd_s    op_cmd_o,
   output logic             debug_enable_o,
   output logic             swap_active_o,
   output logic [2:0]       swap_size_o
);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic        req;
   logic        wr;
   logic        full_word;
   logic [31:0] next_dat;

   assign req       = cyc_i && stb_i && !ack_o;
   assign wr        = req && we_i;
   assign full_word = (sel_i == 4'hF);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic        secure_enable;
   logic [7:0]  page_guard;
   logic [31:1] block_guard;
   logic        key_armed;
   logic [4:0]  key_count;
   fpss_state_e state;
   logic        failed;
   logic        auto_op_idle;
   logic        aborted;
   logic [1:0]  swap_phase;
   logic [2:0]  swap_size;
   logic [5:0]  swap_flags;
   logic [2:0]  area0;
   logic [2:0]  area1;
   logic [2:0]  auto_op_cancel;
   logic [2:0]  abort_clear;
   logic [4:0]  wclk_div;
   logic [1:0]  prog_cnt;
   logic [3:0]  erase_cnt;
   fpss_cmd_s   cmd_hold;
   logic        cmd_go;

   // ------------------------------------------------------------
   // Protection evaluation
   // ------------------------------------------------------------
   logic all_guarded;
   logic secured;
   logic [7:0]  eff_page;
   logic [31:1] eff_block;
   fpss_cmd_s   wcmd;
   logic        cmd_write;
   logic        target_guarded;
   logic        is_cancel;

   assign all_guarded = (&page_guard) && (&block_guard);
   assign secured     = secure_enable && all_guarded;
   assign eff_page    = secure_enable ? page_guard : 8'h00;
   assign eff_block   = secure_enable ? block_guard : 31'h0;
   assign cmd_write   = wr && (adr_i == FPSS_OFF_CMD);
   assign is_cancel   = wr && (adr_i == FPSS_OFF_OPCTL) && (dat_i[2:0] == FPSS_ABORT_CODE);

   // ------------------------------------------------------------
   // Command word unpacking
   // ------------------------------------------------------------
   // Bit 6 of the command word is a spare, so fields are picked one by one
   // instead of a cast, which keeps the flags at the bottom of the word
   always_comb begin
      wcmd           = '0;
      wcmd.opcode    = dat_i[23:20];
      wcmd.block     = dat_i[19:15];
      wcmd.page      = dat_i[14:12];
      wcmd.swap_bits = dat_i[11:10];
      wcmd.swap_size = dat_i[9:7];
      wcmd.flags     = dat_i[5:0];
   end

   // Page guard applies only inside block 0, except for chip erase, which any guard bit refuses
   function automatic logic guarded(input fpss_cmd_s c, input logic [7:0] pg,
                                    input logic [31:1] bk);
      logic g;
      g = 1'b0;
      if (c.block == 5'h00) begin
         g = pg[c.page];
      end else begin
         g = bk[c.block];
      end
      if (c.opcode == FPSS_CMD_CHIP_ERASE) begin
         g = (|pg) || (|bk);
      end
      return g;
   endfunction

   assign target_guarded = guarded(wcmd, eff_page, eff_block);

   // Command acceptance: idle, area selected, not secured (except protect erase)
   logic area_ok;
   logic accept;
   logic refuse_guard;
   assign area_ok      = (area0 == FPSS_AREA_SEL) || (area1 == FPSS_AREA_SEL);
   assign refuse_guard = target_guarded && (wcmd.opcode != FPSS_CMD_PROT_PROG)
                         && (wcmd.opcode != FPSS_CMD_PROT_ERASE)
                         && (wcmd.opcode != FPSS_CMD_SWAP);
   always_comb begin
      accept = cmd_write && area_ok && (state == FPSS_IDLE) && !refuse_guard;
      // Protect erase stays open while secured: it is the only command that leads out
      if (secured && wcmd.opcode != FPSS_CMD_PROT_ERASE) begin
         accept = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Security lock with keyed unlock
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      // Narrow writes never arm or fire the key, so a byte store cannot
      // half-update the lock; a late data write is simply dropped
      if (rst_i || cold_rst_i || stop_wake_i) begin
         secure_enable <= FPSS_RST_SECURE;
         key_armed     <= 1'b0;
         key_count     <= 5'h00;
      end else if (wr && adr_i == FPSS_OFF_SECLOCK && full_word) begin
         if (key_armed) begin
            secure_enable <= dat_i[0];
            key_armed     <= 1'b0;
         end else if (dat_i == FPSS_UNLOCK_KEY) begin
            key_armed <= 1'b1;
            key_count <= 5'h00;
         end
      end else if (key_armed) begin
         if (key_count == FPSS_KEY_WINDOW - 5'h01) begin
            key_armed <= 1'b0;
         end
         key_count <= key_count + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // Automatic operation sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state    <= FPSS_IDLE;
         failed   <= 1'b0;
         cmd_go   <= 1'b0;
         cmd_hold <= '0;
      end else begin
         cmd_go <= 1'b0;
         unique case (state)
            FPSS_IDLE: begin
               if (accept) begin
                  state    <= FPSS_BUSY;
                  cmd_go   <= 1'b1;
                  cmd_hold <= wcmd;
                  if (secured) begin
                     cmd_hold.opcode <= FPSS_CMD_CHIP_ERASE;
                  end
               end
            end
            FPSS_BUSY: begin
               if (is_cancel) begin
                  state  <= FPSS_IDLE;
                  failed <= 1'b0;
               end else if (op_fail_i) begin
                  failed <= 1'b1;
               end else if (op_done_i && !failed) begin
                  state <= FPSS_IDLE;
               end
            end
         endcase
      end
   end

   assign auto_op_idle = (state == FPSS_IDLE);

   // ------------------------------------------------------------
   // Guard bits, updated when the engine finishes
   // ------------------------------------------------------------
   logic finish;
   // A failure or an abort in the done cycle must leave the guards alone
   assign finish = (state == FPSS_BUSY) && op_done_i && !failed && !op_fail_i && !is_cancel;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         page_guard  <= 8'h00;
         block_guard <= 31'h0;
      end else if (finish) begin
         if (cmd_hold.opcode == FPSS_CMD_PROT_PROG) begin
            if (cmd_hold.block == 5'h00) begin
               page_guard[cmd_hold.page] <= 1'b1;
            end else begin
               block_guard[cmd_hold.block] <= 1'b1;
            end
         end else if (cmd_hold.opcode == FPSS_CMD_PROT_ERASE
                      || cmd_hold.opcode == FPSS_CMD_CHIP_ERASE) begin
            page_guard  <= 8'h00;
            block_guard <= 31'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // Swap state, changed by the swap command and cleared by a protect erase run while not secured (secured, it runs as chip erase)
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         swap_phase <= FPSS_SWP_IDLE;
         swap_size  <= 3'h0;
         swap_flags <= 6'h00;
      end else if (finish) begin
         if (cmd_hold.opcode == FPSS_CMD_SWAP) begin
            // Release wins when both bits are asked, avoiding the code 10
            if (cmd_hold.swap_bits[1]) begin
               swap_phase <= 2'h3;
            end else if (cmd_hold.swap_bits[0]) begin
               swap_phase <= FPSS_SWP_ACTIVE;
            end
            // Prohibited size codes keep the previous size
            if (cmd_hold.swap_size <= FPSS_SIZE_MAX) begin
               swap_size <= cmd_hold.swap_size;
            end
            swap_flags <= cmd_hold.flags;
         end else if (cmd_hold.opcode == FPSS_CMD_PROT_ERASE) begin
            swap_phase <= FPSS_SWP_IDLE;
            swap_size  <= 3'h0;
            swap_flags <= 6'h00;
         end
      end
   end

   // ------------------------------------------------------------
   // Plain control registers and abort status
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         area0          <= 3'h0;
         area1          <= 3'h0;
         auto_op_cancel <= 3'h0;
         abort_clear    <= 3'h0;
         wclk_div       <= 5'h00;
         prog_cnt       <= 2'h0;
         erase_cnt      <= FPSS_RST_ERASECNT;
      end else if (wr) begin
         unique case (adr_i)
            FPSS_OFF_AREA: begin
               area0 <= dat_i[2:0];
               area1 <= dat_i[6:4];
            end
            FPSS_OFF_OPCTL:    auto_op_cancel <= dat_i[2:0];
            FPSS_OFF_ABCLR:    abort_clear    <= dat_i[2:0];
            FPSS_OFF_WCLKDIV:  wclk_div       <= dat_i[4:0];
            FPSS_OFF_PROGCNT:  prog_cnt       <= dat_i[1:0];
            FPSS_OFF_ERASECNT: erase_cnt      <= dat_i[3:0];
            default: ;
         endcase
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aborted <= 1'b0;
      end else if (is_cancel && state == FPSS_BUSY) begin
         aborted <= 1'b1;
      end else if (wr && adr_i == FPSS_OFF_ABCLR && dat_i[2:0] == FPSS_ABORT_CODE) begin
         aborted <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read mux and acknowledge
   // ------------------------------------------------------------
   always_comb begin
      next_dat = 32'h0;
      unique case (adr_i)
         FPSS_OFF_SECLOCK:  next_dat[0] = secure_enable;
         FPSS_OFF_PROT_LO: begin
            next_dat[31:FPSS_BLK_LO_POS]  = block_guard[15:1];
            next_dat[15:FPSS_PAGE_POS]    = page_guard;
            next_dat[0]                   = auto_op_idle;
         end
         FPSS_OFF_PROT_HI: begin
            next_dat[31:FPSS_BLK_HI_POS] = block_guard[31:16];
            // Constant one: the high word has no ready flag of its own
            next_dat[0]                  = 1'b1;
         end
         FPSS_OFF_ABSTAT:   next_dat[FPSS_ABORTED_POS] = aborted;
         FPSS_OFF_SWAP: begin
            next_dat[10:FPSS_SWSIZE_POS] = swap_size;
            next_dat[7:FPSS_FLAG_POS]    = swap_flags;
            next_dat[1:0]                = swap_phase;
         end
         FPSS_OFF_AREA:     next_dat[6:0] = {area1, 1'b0, area0};
         FPSS_OFF_OPCTL:    next_dat[2:0] = auto_op_cancel;
         FPSS_OFF_ABCLR:    next_dat[2:0] = abort_clear;
         FPSS_OFF_WCLKDIV:  next_dat[4:0] = wclk_div;
         FPSS_OFF_PROGCNT:  next_dat[1:0] = prog_cnt;
         FPSS_OFF_ERASECNT: next_dat[3:0] = erase_cnt;
         default:           next_dat = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         // One wait state: the write lands at the request edge, ack follows
         ack_o <= req;
         if (req && !we_i) begin
            dat_o <= next_dat;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign op_start_o     = cmd_go;
   assign op_cmd_o       = cmd_hold;
   assign debug_enable_o = !secured;
   assign swap_active_o  = (swap_phase == FPSS_SWP_ACTIVE);
   assign swap_size_o    = swap_size;

endmodule
`default_nettype wire

/* File: dv/fpss_checker.sv */
/*
 Assertions on the ports of fpss_top: bus answer, command launch,
 security status and swap outputs.
 Assumes one clock domain and binding to every fpss_top instance.
*/
`timescale 1ns/10ps
`default_nettype none
module fpss_checker
   import fpss_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cold_rst_i,
   input wire logic        stop_wake_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        op_done_i,
   input wire logic        op_fail_i,
   input wire logic        op_start_o,
   input wire fpss_cmd_s   op_cmd_o,
   input wire logic        debug_enable_o,
   input wire logic        swap_active_o,
   input wire logic [2:0]  swap_size_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // Bus answer and command launch
   // ------------------------------------------------------------
   a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered in the next cycle");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held beyond one cycle");
   a_read_data_held: assert property ($changed(dat_o) |-> ack_o && !we_i || $past(rst_i))
      else $error("read data changed without a read answer");
   a_start_from_cmd: assert property (
      op_start_o |-> $past(cyc_i && stb_i && we_i && !ack_o && adr_i == FPSS_OFF_CMD))
      else $error("command launched without a command write");
   a_start_one_pulse: assert property (op_start_o |=> !op_start_o)
      else $error("command launch longer than one cycle");
   a_cmd_held_val: assert property ($changed(op_cmd_o) |-> op_start_o || $past(rst_i))
      else $error("command changed without a launch");
   // ------------------------------------------------------------
   // Security and swap
   // ------------------------------------------------------------
   // Debug low means secured: only the converted protect erase may launch
   a_secured_cmd_chip: assert property (
      op_start_o && !$past(debug_enable_o) |-> op_cmd_o.opcode == FPSS_CMD_CHIP_ERASE)
      else $error("command launched while secured");
   a_debug_fall_why: assert property (
      $fell(debug_enable_o) |->
      $past(op_done_i || cold_rst_i || stop_wake_i || cyc_i && stb_i && we_i))
      else $error("debug disabled without a cause");
   a_debug_rise_why: assert property (
      $rose(debug_enable_o) |-> $past(op_done_i || rst_i || cyc_i && stb_i && we_i))
      else $error("debug enabled without a cause");
   a_swap_change_why: assert property (
      $changed(swap_active_o) || $changed(swap_size_o) |-> $past(op_done_i || rst_i))
      else $error("swap state changed outside a finished command");
   c_launch: cover property (op_start_o);
   c_secured: cover property ($fell(debug_enable_o));
   c_swapping: cover property ($rose(swap_active_o));
endmodule
bind fpss_top fpss_checker u_chk (.clk_i, .rst_i, .cold_rst_i, .stop_wake_i, .cyc_i, .stb_i,
   .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .op_done_i, .op_fail_i, .op_start_o,
   .op_cmd_o, .debug_enable_o, .swap_active_o, .swap_size_o);
`default_nettype wire

/* File: dv/fpss_top_tb_top.sv */
/*
 Self-checking bench for fpss_top: Wishbone register traffic, commands,
 engine pulses and security keys.
 Assumes the command register at FPSS_OFF_CMD and the checker bound.
*/
`timescale 1ns/10ps
`default_nettype none
module fpss_top_tb_top
   import fpss_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i, stb_i, we_i;
   logic [11:0] adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rnd;
   logic        ack_o, op_start_o, debug_enable_o, swap_active_o;
   logic [2:0]  swap_size_o;
   fpss_cmd_s   op_cmd_o;
   // Engine done, engine fail, cold reset, deep-stop wake
   logic [3:0]  pz;
   logic [31:0] rq[$];
   logic [22:0] cq[$];
   int          num_errors = 0;
   int          num_checks = 0;
   int          seed = 32'hE1EC332A;

   fpss_top DUT (.clk_i, .rst_i, .cold_rst_i(pz[2]), .stop_wake_i(pz[3]), .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .op_done_i(pz[0]), .op_fail_i(pz[1]),
      .op_start_o, .op_cmd_o, .debug_enable_o, .swap_active_o, .swap_size_o);

   always #20 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, a, 32'h0, 4'hF);
   endtask

   task automatic pulse(input int k);
      @(posedge clk_i);
      pz[k] <= 1'b1;
      @(posedge clk_i);
      pz[k] <= 1'b0;
      @(posedge clk_i);
   endtask

   // Accepted commands are noted with the opcode expected at the engine
   task automatic cmd(input logic [3:0] op, input logic [4:0] b, input logic [2:0] p,
                      input logic [4:0] sw, input logic [3:0] eop, input bit ok, input bit fin);
      if (ok) cq.push_back({eop, b, p, sw, 6'h00});
      wb(1'b1, FPSS_OFF_CMD, {8'h00, op, b, p, sw, 7'h00}, 4'hF);
      if (fin) pulse(0);
   endtask

   task automatic unlock(input logic [3:0] s, input int gap, input logic [31:0] v);
      wb(1'b1, FPSS_OFF_SECLOCK, FPSS_UNLOCK_KEY, s);
      repeat (gap) @(posedge clk_i);
      wb(1'b1, FPSS_OFF_SECLOCK, v, 4'hF);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Result monitor and watchdog
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) check_word("read data", rq.pop_front(), dat_o);
      if (op_start_o === 1'b1) begin
         if (cq.size() == 0) check_word("unexpected launch", 32'h0, 32'h1);
         else check_word("command", {9'h000, cq.pop_front()}, {9'h000, op_cmd_o});
      end
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      final_report();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {cyc_i, stb_i, we_i, pz, adr_i, sel_i, dat_i} = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(FPSS_OFF_SECLOCK, 32'h1);
      rd(FPSS_OFF_PROT_LO, 32'h1);
      rd(FPSS_OFF_PROT_HI, 32'h1);
      rd(FPSS_OFF_SWAP, 32'h0);
      rd(FPSS_OFF_ERASECNT, 32'h6);
      rd(12'h0FC, 32'h0);
      wb(1'b1, FPSS_OFF_AREA, 32'h77, 4'hF);
      rd(FPSS_OFF_AREA, 32'h77);
      for (int i = 0; i < 4; i++) begin
         rnd = $random(seed);
         wb(1'b1, FPSS_OFF_WCLKDIV, rnd, 4'hF);
         rd(FPSS_OFF_WCLKDIV, {27'h0, rnd[4:0]});
      end
      // Busy flag, dropped command while busy, block guard
      cmd(FPSS_CMD_PROT_PROG, 5'h3, 3'h0, 5'h0, FPSS_CMD_PROT_PROG, 1, 0);
      rd(FPSS_OFF_PROT_LO, 32'h0);
      cmd(FPSS_CMD_PROGRAM, 5'h5, 3'h0, 5'h0, FPSS_CMD_PROGRAM, 0, 0);
      pulse(0);
      rd(FPSS_OFF_PROT_LO, 32'h0008_0001);
      check_word("debug", 32'h1, {31'h0, debug_enable_o});
      cmd(FPSS_CMD_PROGRAM, 5'h3, 3'h0, 5'h0, FPSS_CMD_PROGRAM, 0, 0);
      cmd(FPSS_CMD_PROGRAM, 5'h4, 3'h0, 5'h0, FPSS_CMD_PROGRAM, 1, 1);
      cmd(FPSS_CMD_PROT_PROG, 5'h0, 3'h5, 5'h0, FPSS_CMD_PROT_PROG, 1, 1);
      rd(FPSS_OFF_PROT_LO, 32'h0008_2001);
      cmd(FPSS_CMD_PAGE_ERASE, 5'h0, 3'h5, 5'h0, FPSS_CMD_PAGE_ERASE, 0, 0);
      cmd(FPSS_CMD_PAGE_ERASE, 5'h0, 3'h4, 5'h0, FPSS_CMD_PAGE_ERASE, 1, 1);
      cmd(FPSS_CMD_CHIP_ERASE, 5'h0, 3'h0, 5'h0, FPSS_CMD_CHIP_ERASE, 0, 0);
      cmd(FPSS_CMD_BLK_ERASE, 5'h3, 3'h0, 5'h0, FPSS_CMD_BLK_ERASE, 0, 0);
      cmd(FPSS_CMD_BLK_ERASE, 5'h6, 3'h0, 5'h0, FPSS_CMD_BLK_ERASE, 1, 1);
      // Security bit rewrite: good key, bad width, late data
      unlock(4'hF, 0, 32'h0);
      rd(FPSS_OFF_SECLOCK, 32'h0);
      cmd(FPSS_CMD_PROGRAM, 5'h3, 3'h0, 5'h0, FPSS_CMD_PROGRAM, 1, 1);
      rd(FPSS_OFF_PROT_LO, 32'h0008_2001);
      unlock(4'h3, 0, 32'h1);
      rd(FPSS_OFF_SECLOCK, 32'h0);
      unlock(4'hF, 20, 32'h1);
      rd(FPSS_OFF_SECLOCK, 32'h0);
      unlock(4'hF, 0, 32'h1);
      rd(FPSS_OFF_SECLOCK, 32'h1);
      // Guard everything, then secured behaviour
      for (int i = 0; i < 39; i++) begin
         if (i != 5 && i != 10) begin
            cmd(FPSS_CMD_PROT_PROG, (i < 8) ? 5'h0 : 5'(i - 7), (i < 8) ? 3'(i) : 3'h0, 5'h0,
                FPSS_CMD_PROT_PROG, 1, 1);
         end
      end
      check_word("debug", 32'h0, {31'h0, debug_enable_o});
      rd(FPSS_OFF_PROT_LO, 32'hFFFE_FF01);
      rd(FPSS_OFF_PROT_HI, 32'hFFFF_0001);
      cmd(FPSS_CMD_PROGRAM, 5'h7, 3'h0, 5'h0, FPSS_CMD_PROGRAM, 0, 0);
      cmd(FPSS_CMD_PROT_PROG, 5'h7, 3'h0, 5'h0, FPSS_CMD_PROT_PROG, 0, 0);
      cmd(FPSS_CMD_PROT_ERASE, 5'h0, 3'h0, 5'h0, FPSS_CMD_CHIP_ERASE, 1, 1);
      rd(FPSS_OFF_PROT_LO, 32'h1);
      rd(FPSS_OFF_PROT_HI, 32'h1);
      check_word("debug", 32'h1, {31'h0, debug_enable_o});
      // Failed operation and abort
      cmd(FPSS_CMD_PROGRAM, 5'h2, 3'h0, 5'h0, FPSS_CMD_PROGRAM, 1, 0);
      pulse(1);
      rd(FPSS_OFF_PROT_LO, 32'h0);
      wb(1'b1, FPSS_OFF_OPCTL, {29'h0, FPSS_ABORT_CODE}, 4'hF);
      rd(FPSS_OFF_OPCTL, 32'h7);
      rd(FPSS_OFF_PROT_LO, 32'h1);
      rd(FPSS_OFF_ABSTAT, 32'h0100_0000);
      wb(1'b1, FPSS_OFF_ABCLR, 32'h7, 4'hF);
      rd(FPSS_OFF_ABSTAT, 32'h0);
      wb(1'b1, FPSS_OFF_OPCTL, 32'h0, 4'hF);
      // Swap start and release
      cmd(FPSS_CMD_SWAP, 5'h0, 3'h0, 5'b01011, FPSS_CMD_SWAP, 1, 1);
      check_word("swap", 32'hB, {28'h0, swap_active_o, swap_size_o});
      rd(FPSS_OFF_SWAP, 32'h0000_0301);
      cmd(FPSS_CMD_SWAP, 5'h0, 3'h0, 5'b10011, FPSS_CMD_SWAP, 1, 1);
      check_word("swap", 32'h3, {28'h0, swap_active_o, swap_size_o});
      // Cold reset and deep-stop wake restore the security bit
      for (int k = 2; k < 4; k++) begin
         unlock(4'hF, 0, 32'h0);
         rd(FPSS_OFF_SECLOCK, 32'h0);
         pulse(k);
         rd(FPSS_OFF_SECLOCK, 32'h1);
      end
      repeat (3) @(posedge clk_i);
      check_word("pending notes", 32'h0, rq.size() + cq.size());
      final_report();
   end
endmodule
`default_nettype wire
